// >>> hw/rsi_pkg.sv
// Types shared by the receiver status indicator.
// Constants live in rsi_regs.svh.
package rsi_pkg;

    typedef enum logic [6:0] {
        RSI_IND_DARK = 7'b0000001,
        RSI_IND_READY = 7'b0000010,
        RSI_IND_RESERVE = 7'b0000100,
        RSI_IND_TEACH = 7'b0001000,
        RSI_IND_TEACH_FAIL = 7'b0010000,
        RSI_IND_SYS_ERR = 7'b0100000,
        RSI_IND_SOIL = 7'b1000000
    } rsi_ind_t;

    typedef struct packed {
        logic green;
        logic yellow;
    } rsi_leds_t;

    typedef struct packed {
        logic prefix_valid;
        logic [15:0] code;
        logic [3:0][7:0] digits;
    } rsi_display_t;

    typedef struct packed {
        logic ready;
        logic startup;
        logic reserve_missing;
        logic system_error;
        logic soiling;
        logic reconfig;
        logic meas_inactive;
        logic teach_params_changed;
        logic shutdown;
        logic config_active;
    } rsi_cond_t;

endpackage

// >>> hw/rsi_regs.svh
// Timing and status code constants for the receiver status indicator.
// Assumes a 100 MHz system clock; included by bare name.
`ifndef RSI_REGS_SVH
`define RSI_REGS_SVH

`define RSI_CLK_HZ 100000000
`define RSI_FLASH_FAST_HZ 15
`define RSI_FLASH_MID_HZ 9
`define RSI_FLASH_SLOW_HZ 3
`define RSI_HALF_FAST (`RSI_CLK_HZ / (2 * `RSI_FLASH_FAST_HZ))
`define RSI_HALF_MID (`RSI_CLK_HZ / (2 * `RSI_FLASH_MID_HZ))
`define RSI_HALF_SLOW (`RSI_CLK_HZ / (2 * `RSI_FLASH_SLOW_HZ))
`define RSI_TB_WIDTH 25

`define RSI_CODE_NONE 16'h0000
`define RSI_CODE_STARTUP 16'h0100
`define RSI_CODE_RECONFIG 16'h0180
`define RSI_CODE_INACTIVE 16'h0190
`define RSI_CODE_SOILING 16'h0200
`define RSI_CODE_TEACH_PARAM 16'h0300
`define RSI_CODE_SHUTDOWN 16'h0FFF

`define RSI_RESERVE_OFF 2'h0
`define RSI_RESERVE_LOW 2'h1
`define RSI_RESERVE_MED 2'h2
`define RSI_RESERVE_HIGH 2'h3

`endif

// >>> hw/rsi_status.sv
// Receiver status indicator: LED patterns and display status codes.
// Assumes all condition inputs are synchronous to clk_in.
`timescale 1ns/10ps
`include "rsi_regs.svh"

module rsi_status
    import rsi_pkg::*;
#(
    parameter int HALF_FAST = `RSI_HALF_FAST,
    parameter int HALF_MID = `RSI_HALF_MID,
    parameter int HALF_SLOW = `RSI_HALF_SLOW,
    parameter int OUT_W = 2,
    parameter int LEVEL_W = 16
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Device conditions
    input wire rsi_cond_t cond_in,
    input wire logic [1:0] reserve_mode_in,
    // Teach control and beam samples
    input wire logic teach_start_in,
    input wire logic teach_end_in,
    input wire logic beam_valid_in,
    input wire logic [LEVEL_W-1:0] beam_level_in,
    input wire logic [LEVEL_W-1:0] band_low_in,
    input wire logic [LEVEL_W-1:0] band_high_in,
    // Switching outputs from the evaluation
    input wire logic [OUT_W-1:0] switch_in,
    // Indicators and display
    output rsi_leds_t leds_out,
    output rsi_display_t display_out,
    output logic data_invalid_out,
    output logic teaching_out,
    output logic [OUT_W-1:0] switch_out
);

    localparam logic [`RSI_TB_WIDTH-1:0] HALF_LIM [3] = '{
        `RSI_TB_WIDTH'(HALF_FAST - 1), `RSI_TB_WIDTH'(HALF_MID - 1),
        `RSI_TB_WIDTH'(HALF_SLOW - 1)};
    // Refuse counts the time base or the ports cannot serve
    if (HALF_FAST < 1 || HALF_MID < 1 || HALF_SLOW < 1 || OUT_W < 1 ||
        LEVEL_W < 1 || HALF_SLOW >= (1 << `RSI_TB_WIDTH) ||
        HALF_MID >= (1 << `RSI_TB_WIDTH) ||
        HALF_FAST >= (1 << `RSI_TB_WIDTH)) begin : g_bad_cfg
        $error("rsi_status: half period or width out of range");
    end

    function automatic logic [7:0] hex_char(input logic [3:0] nib);
        hex_char = (nib < 4'hA) ? (8'h30 + {4'h0, nib}) :
                                  (8'h37 + {4'h0, nib});
    endfunction

    // Common time base: one phase toggle per flash rate
    logic [2:0][`RSI_TB_WIDTH-1:0] cnt_reg;
    logic [2:0][`RSI_TB_WIDTH-1:0] cnt_next;
    logic [2:0] phase_reg;
    logic [2:0] phase_next;

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_rate
            always_comb begin
                if (cnt_reg[gi] == HALF_LIM[gi]) begin
                    cnt_next[gi] = '0;
                    phase_next[gi] = ~phase_reg[gi];
                end else begin
                    cnt_next[gi] = cnt_reg[gi] + `RSI_TB_WIDTH'h1;
                    phase_next[gi] = phase_reg[gi];
                end
            end
        end
    endgenerate
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            cnt_reg <= '0;
            phase_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
            phase_reg <= phase_next;
        end
    end

    wire logic ph_fast = phase_reg[0];
    wire logic ph_mid = phase_reg[1];
    wire logic ph_slow = phase_reg[2];
    // Teach supervision
    logic teach_reg;
    logic teach_next;
    logic fail_reg;
    logic fail_next;
    logic beam_bad;

    always_comb begin
        beam_bad = beam_valid_in && (beam_level_in < band_low_in ||
                                     beam_level_in > band_high_in);
        teach_next = teach_reg;
        fail_next = fail_reg;
        if (teach_start_in) begin
            teach_next = 1'b1;
            fail_next = 1'b0;
        end else if (teach_reg && beam_bad) begin
            teach_next = 1'b0;
            fail_next = 1'b1;
        end else if (teach_reg && teach_end_in) begin
            teach_next = 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            teach_reg <= 1'b0;
            fail_reg <= 1'b0;
        end else begin
            teach_reg <= teach_next;
            fail_reg <= fail_next;
        end
    end

    // Indicator mode, highest priority first
    rsi_ind_t ind_reg;
    rsi_ind_t ind_next;
    logic soil_shown;

    always_comb begin
        soil_shown = cond_in.soiling &&
                     reserve_mode_in != `RSI_RESERVE_OFF;
        if (cond_in.system_error) begin
            ind_next = RSI_IND_SYS_ERR;
        end else if (fail_reg) begin
            ind_next = RSI_IND_TEACH_FAIL;
        end else if (teach_reg) begin
            ind_next = RSI_IND_TEACH;
        end else if (!cond_in.ready || cond_in.startup) begin
            ind_next = RSI_IND_DARK;
        end else if (soil_shown) begin
            ind_next = RSI_IND_SOIL;
        end else if (cond_in.reserve_missing) begin
            ind_next = RSI_IND_RESERVE;
        end else begin
            ind_next = RSI_IND_READY;
        end
    end
    rsi_leds_t leds_next;
    always_comb begin
        unique case (ind_reg)
            RSI_IND_DARK: leds_next = '{green: 1'b0, yellow: 1'b0};
            RSI_IND_READY: leds_next = '{green: 1'b1, yellow: 1'b0};
            RSI_IND_RESERVE,
            RSI_IND_SOIL: leds_next = '{green: 1'b0, yellow: ph_fast};
            RSI_IND_TEACH: leds_next = '{green: ph_slow, yellow: ph_slow};
            RSI_IND_TEACH_FAIL: leds_next = '{green: ph_mid,
                                              yellow: ph_mid};
            RSI_IND_SYS_ERR: leds_next = '{green: ph_mid,
                                           yellow: ~ph_mid};
            default: leds_next = '{green: 1'b0, yellow: 1'b0};
        endcase
    end

    // Status code selection
    rsi_display_t disp_reg;
    rsi_display_t disp_next;
    logic invalid_reg;
    logic invalid_next;
    logic [OUT_W-1:0] sw_reg;
    logic [OUT_W-1:0] sw_next;
    logic [15:0] code;
    always_comb begin
        invalid_next = 1'b0;
        if (cond_in.shutdown) begin
            code = `RSI_CODE_SHUTDOWN;
            invalid_next = 1'b1;
        end else if (cond_in.reconfig) begin
            code = `RSI_CODE_RECONFIG;
            invalid_next = 1'b1;
        end else if (cond_in.startup) begin
            code = `RSI_CODE_STARTUP;
        end else if (cond_in.meas_inactive) begin
            code = `RSI_CODE_INACTIVE;
        end else if (cond_in.soiling) begin
            code = `RSI_CODE_SOILING;
        end else if (cond_in.teach_params_changed) begin
            code = `RSI_CODE_TEACH_PARAM;
        end else begin
            code = `RSI_CODE_NONE;
        end
        disp_next.prefix_valid = (code != `RSI_CODE_NONE);
        disp_next.code = code;
        for (int i = 0; i < 4; i++) begin
            disp_next.digits[i] = hex_char(code[4*i +: 4]);
        end
        sw_next = cond_in.config_active ? '0 : switch_in;
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ind_reg <= RSI_IND_DARK;
            leds_out <= '0;
            disp_reg <= '0;
            invalid_reg <= 1'b0;
            sw_reg <= '0;
        end else begin
            ind_reg <= ind_next;
            leds_out <= leds_next;
            disp_reg <= disp_next;
            invalid_reg <= invalid_next;
            sw_reg <= sw_next;
        end
    end

    assign display_out = disp_reg;
    assign data_invalid_out = invalid_reg;
    assign teaching_out = teach_reg;
    assign switch_out = sw_reg;
    property p_ready_green;
        @(posedge clk_in) disable iff (rst_in)
        ind_reg == RSI_IND_READY |=> leds_out.green && !leds_out.yellow;
    endproperty
    a_ready_green: assert property (p_ready_green)
        else $error("ready must show steady green only");
    property p_not_ready_dark;
        @(posedge clk_in) disable iff (rst_in)
        !cond_in.ready && !cond_in.system_error && !teach_reg && !fail_reg
            |-> ##2 leds_out == '0;
    endproperty
    a_not_ready_dark: assert property (p_not_ready_dark)
        else $error("not ready must keep both indicators dark");
    property p_reserve_flash;
        @(posedge clk_in) disable iff (rst_in)
        ind_reg == RSI_IND_RESERVE |=>
            !leds_out.green && leds_out.yellow == $past(ph_fast);
    endproperty
    a_reserve_flash: assert property (p_reserve_flash)
        else $error("missing reserve must flash yellow at fast rate");
    property p_alt_flash;
        @(posedge clk_in) disable iff (rst_in)
        ind_reg == RSI_IND_SYS_ERR |=> leds_out.green != leds_out.yellow;
    endproperty
    a_alt_flash: assert property (p_alt_flash)
        else $error("system error must flash alternately");
    property p_beam_fail;
        @(posedge clk_in) disable iff (rst_in)
        teach_reg && beam_bad && !teach_start_in |=>
            fail_reg && !teach_reg ##1 ind_reg == RSI_IND_TEACH_FAIL ||
            ind_reg == RSI_IND_SYS_ERR;
    endproperty
    a_beam_fail: assert property (p_beam_fail)
        else $error("beam outside band must fail teaching");
    property p_soil_gate;
        @(posedge clk_in) disable iff (rst_in)
        reserve_mode_in == `RSI_RESERVE_OFF |=> ind_reg != RSI_IND_SOIL;
    endproperty
    a_soil_gate: assert property (p_soil_gate)
        else $error("soiling shown with reserve mode off");
    property p_config_quiet;
        @(posedge clk_in) disable iff (rst_in)
        cond_in.config_active |=> switch_out == '0;
    endproperty
    a_config_quiet: assert property (p_config_quiet)
        else $error("switching outputs active during configuration");
    property p_shutdown_code;
        @(posedge clk_in) disable iff (rst_in)
        cond_in.shutdown |=> display_out.code == `RSI_CODE_SHUTDOWN &&
            data_invalid_out && display_out.digits[3] == 8'h30;
    endproperty
    a_shutdown_code: assert property (p_shutdown_code)
        else $error("shutdown must report its code with invalid data");
    property p_reconfig_code;
        @(posedge clk_in) disable iff (rst_in)
        cond_in.reconfig && !cond_in.shutdown |=>
            display_out.code == `RSI_CODE_RECONFIG && data_invalid_out;
    endproperty
    a_reconfig_code: assert property (p_reconfig_code)
        else $error("reconfiguration must report its code");
    property p_fast_half;
        @(posedge clk_in) disable iff (rst_in)
        $rose(ph_fast) |-> ph_fast && cnt_reg[0] == `RSI_TB_WIDTH'h0;
    endproperty
    a_fast_half: assert property (p_fast_half)
        else $error("fast flash phase misaligned with time base");

endmodule

// >>> tb/rsi_operator.sv
// Operator model: times the yellow LED runs and reads the display digits.
// Assumes leds and display are registered outputs sampled on clk_in.
`timescale 1ns/10ps
module rsi_operator
    import rsi_pkg::*;
(
    // Clock
    input wire logic clk_in,
    // Observed device outputs
    input wire rsi_leds_t leds_in,
    input wire rsi_display_t display_in,
    // What the operator noted
    output logic [31:0] y_on_out,
    output logic [31:0] y_off_out,
    output logic [15:0] shown_code_out
);
    logic [31:0] y_run = 0;
    logic y_last = 0;
    logic [31:0] y_on = 0;
    logic [31:0] y_off = 0;

    assign y_on_out = y_on;
    assign y_off_out = y_off;

    // A run ends when yellow changes; its length is kept by level
    always @(posedge clk_in) begin
        y_last <= leds_in.yellow;
        if (leds_in.yellow !== y_last) begin
            if (y_last) y_on <= y_run;
            else y_off <= y_run;
            y_run <= 1;
        end else begin
            y_run <= y_run + 1;
        end
    end

    function automatic logic [3:0] nib(input logic [7:0] c);
        return (c >= 8'h41) ? 4'(c - 8'h37) : 4'(c - 8'h30);
    endfunction

    // Reads the four hex characters back into a code
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            shown_code_out[4*i+:4] = nib(display_in.digits[i]);
        end
    end
endmodule

// >>> tb/rsi_status_tb.sv
// Self-checking bench for the receiver status indicator.
// Assumes shortened flash counts; the operator model watches outputs.
`timescale 1ns/10ps
module rsi_status_tb import rsi_pkg::*;;
    localparam int HF = 3;
    localparam int HM = 5;
    localparam int HS = 16;
    logic clk_in = 1'h0;
    logic rst_in;
    rsi_cond_t cond;
    logic [1:0] reserve_mode_in;
    logic teach_start_in;
    logic teach_end_in;
    logic beam_valid_in;
    logic [15:0] beam_level_in;
    logic [15:0] band_low_in;
    logic [15:0] band_high_in;
    logic [1:0] switch_in;
    rsi_leds_t leds_out;
    rsi_display_t display_out;
    logic data_invalid_out;
    logic teaching_out;
    logic [1:0] switch_out;
    logic [31:0] y_on;
    logic [31:0] y_off;
    logic [15:0] shown;
    int errors = 0;
    int checked = 0;
    logic [9:0] cvec [7] = '{10'h002, 10'h010, 10'h100, 10'h008,
        10'h020, 10'h004, 10'h000};
    logic [15:0] cexp [7] = '{16'h0FFF, 16'h0180, 16'h0100, 16'h0190,
        16'h0200, 16'h0300, 16'h0000};

    rsi_status #(.HALF_FAST(HF), .HALF_MID(HM), .HALF_SLOW(HS)) i_rsi_status (
        .clk_in(clk_in), .rst_in(rst_in), .cond_in(cond),
        .reserve_mode_in(reserve_mode_in), .teach_start_in(teach_start_in),
        .teach_end_in(teach_end_in), .beam_valid_in(beam_valid_in),
        .beam_level_in(beam_level_in), .band_low_in(band_low_in),
        .band_high_in(band_high_in), .switch_in(switch_in),
        .leds_out(leds_out), .display_out(display_out),
        .data_invalid_out(data_invalid_out), .teaching_out(teaching_out),
        .switch_out(switch_out));

    rsi_operator i_rsi_operator (.clk_in(clk_in), .leds_in(leds_out),
        .display_in(display_out), .y_on_out(y_on), .y_off_out(y_off),
        .shown_code_out(shown));

    task automatic tally_and_finish;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checked++;
        if (seen !== want) begin
            errors++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, want);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_in);
    endtask

    function automatic logic [31:0] digits(input logic [15:0] c);
        for (int i = 0; i < 4; i++) begin
            digits[8*i+:8] = (c[4*i+:4] < 4'hA) ? 8'h30 + c[4*i+:4]
                : 8'h37 + c[4*i+:4];
        end
    endfunction

    // Kind 0: yellow alone, 1: both together, 2: alternating
    task automatic flash(input int half, input int kind);
        int moves;
        int bad;
        logic y;
        moves = 0;
        bad = 0;
        cyc(2 * half + 3);
        y = leds_out.yellow;
        for (int k = 0; k < 4 * half; k++) begin
            cyc(1);
            moves += int'(leds_out.yellow !== y);
            y = leds_out.yellow;
            bad += int'(kind == 0 ? leds_out.green !== 1'h0 : kind == 1 ?
                leds_out.green !== y : leds_out.green === y);
        end
        cyc(1);
        check(moves, 4);
        check(y_on, half);
        check(y_off, half);
        check(bad, 0);
    endtask

    task automatic beam(input bit bad);
        beam_valid_in = 1'h1;
        if (bad) beam_level_in = ($urandom % 2) ? band_low_in - 16'h1
            : band_high_in + 16'h1 + 16'($urandom % 8);
        else beam_level_in = band_low_in + 16'($urandom % 16'hE01);
        cyc(1);
        beam_valid_in = 1'h0;
        cyc(1);
    endtask

    task automatic pulse_start;
        teach_start_in = 1'h1;
        cyc(1);
        teach_start_in = 1'h0;
    endtask

    initial begin
        forever #5 clk_in = ~clk_in;
    end

    initial begin
        #100000;
        errors++;
        tally_and_finish();
    end

    initial begin
        rst_in = 1'h1;
        cond = '0;
        reserve_mode_in = 2'h0;
        teach_start_in = 1'h0;
        teach_end_in = 1'h0;
        beam_valid_in = 1'h0;
        beam_level_in = 16'h0000;
        band_low_in = 16'h0100;
        band_high_in = 16'h0F00;
        switch_in = 2'h0;
        void'($urandom(7));
        cyc(16);
        check({leds_out, teaching_out, data_invalid_out}, 0);
        rst_in = 1'h0;
        // Each code with random lower-priority conditions beside it
        for (int i = 0; i < 7; i++) begin
            cond = cvec[i];
            for (int j = i + 1; j < 7; j++) begin
                if ($urandom % 2) cond = cond | cvec[j];
            end
            cyc(1);
            check(display_out.code, cexp[i]);
            check(display_out.prefix_valid, cexp[i] != 0);
            check(data_invalid_out, i < 2);
            if (cexp[i] != 0) begin
                check(display_out.digits, digits(cexp[i]));
                check(shown, cexp[i]);
            end
        end
        cond = '0;
        cond.ready = 1'h1;
        cyc(3);
        check(leds_out, 2'h2);
        cond.startup = 1'h1;
        cyc(3);
        check(leds_out, 2'h0);
        cond.startup = 1'h0;
        cond.reserve_missing = 1'h1;
        flash(HF, 0);
        cond.reserve_missing = 1'h0;
        cond.soiling = 1'h1;
        cyc(3);
        check(leds_out, 2'h2);
        reserve_mode_in = 2'(1 + $urandom % 3);
        flash(HF, 0);
        cond.soiling = 1'h0;
        pulse_start();
        check(teaching_out, 1);
        for (int k = 0; k < 4; k++) beam(0);
        check(teaching_out, 1);
        flash(HS, 1);
        beam(1);
        check(teaching_out, 0);
        flash(HM, 1);
        cond.system_error = 1'h1;
        flash(HM, 2);
        cond.system_error = 1'h0;
        pulse_start();
        teach_end_in = 1'h1;
        cyc(1);
        teach_end_in = 1'h0;
        check(teaching_out, 0);
        cyc(2);
        check(leds_out, 2'h2);
        for (int k = 0; k < 8; k++) begin
            cond.config_active = (k < 2) ? k[0] : 1'($urandom);
            switch_in = 2'($urandom);
            cyc(1);
            check(switch_out, cond.config_active ? 2'h0 : switch_in);
        end
        tally_and_finish();
    end
endmodule
